// ===== core/dts_top.sv
/*
 * status side of the debug trace unit: control register, comparator hit
 * flags, trace pending flag and the capture count, all behind an apb slave.
 * assumes match, capture, done and reset-event inputs are synchronous
 * single-cycle strobes from the comparator, trigger and fifo logic.
 */
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps

module dts_top (
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    // apb slave
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [dts_pkg::ADDR_W-1:0]     paddr,
    input  wire logic [dts_pkg::DATA_W-1:0]     pwdata,
    output logic [dts_pkg::DATA_W-1:0]          prdata,
    output logic                                pready,
    output logic                                pslverr,
    // comparator match strobes
    input  wire logic                           cmp_a_match,
    input  wire logic                           cmp_b_match,
    input  wire logic                           cmp_c_match,
    // a new word was written into the trace fifo
    input  wire logic                           fifo_word_stored,
    // trigger logic finished the run and drops arming
    input  wire logic                           trace_done,
    // reset events seen by the debug unit
    input  wire logic                           non_end_run_rst,
    input  wire logic                           end_run_rst,
    input  wire logic                           end_trace_rst,
    // state handed to the trigger and fifo logic
    output logic                                debug_unit_on,
    output logic                                trace_armed,
    output logic                                trig_at_start,
    output logic                                capture_enable
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic [dts_pkg::REG_W-1:0]  ctrl_reg;
    logic [dts_pkg::REG_W-1:0]  ctrl_next;
    logic                       cmp_a_hit_flag_reg;
    logic                       cmp_b_hit_flag_reg;
    logic                       cmp_c_hit_flag_reg;
    logic                       cmp_a_hit_flag_next;
    logic                       cmp_b_hit_flag_next;
    logic                       cmp_c_hit_flag_next;
    logic [dts_pkg::DATA_W-1:0] rdata_reg;
    logic [dts_pkg::DATA_W-1:0] rdata_next;
    logic                       slverr_reg;
    logic                       slverr_next;

    logic                       setup_phase;
    logic                       access_phase;
    logic                       hit_ctrl;
    logic                       hit_stat;
    logic                       hit_fill;
    logic                       addr_mapped;
    logic                       ctrl_wr;

    logic                       on_cur;
    logic                       arm_cur;
    logic                       begin_cur;
    logic                       on_wr;
    logic                       arm_wr;
    logic                       begin_wr;
    logic                       on_after;
    logic                       begin_after;
    logic                       arm_after;
    logic                       arm_rise;
    logic                       armed_now;

    logic                       hit_a;
    logic                       hit_b;
    logic                       hit_c;
    logic                       fill_clear;
    logic                       fill_step;
    logic [dts_pkg::FILL_W-1:0] capture_fill_count;

    logic                       trace_pending_flag;
    logic [dts_pkg::REG_W-1:0]  debug_status_reg;
    logic [dts_pkg::REG_W-1:0]  capture_fill_reg;
    logic [dts_pkg::REG_W-1:0]  read_mux;

    dts_pkg::dts_rst_kind_t     rst_kind;
    logic                       keep_state_rst;
    logic                       armed_out_reg;
    logic                       armed_out_next;

    ////////////////////////////////////////////////////////////////////////
    // functions

    // one-hot style address compare, shared by all three registers
    function automatic logic addr_is(
        input logic [dts_pkg::ADDR_W-1:0] addr,
        input logic [dts_pkg::ADDR_W-1:0] ofs
    );
        addr_is = (addr == ofs);
    endfunction : addr_is

    // sticky flag: a match in the arming cycle survives the arming clear
    function automatic logic sticky_next(
        input logic held,
        input logic clr,
        input logic set
    );
        sticky_next = (held & ~clr) | set;
    endfunction : sticky_next

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    assign setup_phase  = psel & ~penable;
    assign access_phase = psel & penable;
    assign hit_ctrl     = addr_is(paddr, dts_pkg::OFS_CTRL);
    assign hit_stat     = addr_is(paddr, dts_pkg::OFS_STAT);
    assign hit_fill     = addr_is(paddr, dts_pkg::OFS_FILL);
    assign addr_mapped  = hit_ctrl | hit_stat | hit_fill;
    // writes to the read-only registers are dropped without error
    assign ctrl_wr      = access_phase & pwrite & hit_ctrl;

    // zero wait states: every access phase completes in one cycle
    // so the master never sees a stretched access
    assign pready       = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // reset-event decode

    // an end-trace reset only preserves state while on with an end trigger;
    // otherwise it is handled like any non-end-run reset
    // events should not overlap; a clash goes to the non-end-run reset first,
    // then end-run, then end-trace
    assign keep_state_rst = on_cur & ~begin_cur;

    always_comb begin
        rst_kind = dts_pkg::DTS_RST_NONE;
        if (non_end_run_rst) begin
            rst_kind = dts_pkg::DTS_RST_FULL;
        end else if (end_run_rst) begin
            rst_kind = dts_pkg::DTS_RST_END_RUN;
        end else if (end_trace_rst) begin
            rst_kind = keep_state_rst ? dts_pkg::DTS_RST_END_TRACE
                                      : dts_pkg::DTS_RST_FULL;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control register

    assign on_cur    = ctrl_reg[dts_pkg::CTRL_ON_BIT];
    assign arm_cur   = ctrl_reg[dts_pkg::CTRL_ARM_BIT];
    assign begin_cur = ctrl_reg[dts_pkg::CTRL_BEGIN_BIT];
    assign on_wr     = pwdata[dts_pkg::CTRL_ON_BIT];
    assign arm_wr    = pwdata[dts_pkg::CTRL_ARM_BIT];
    assign begin_wr  = pwdata[dts_pkg::CTRL_BEGIN_BIT];

    assign on_after    = ctrl_wr ? on_wr : on_cur;
    // trigger placement is frozen while a run is armed
    assign begin_after = (ctrl_wr & ~arm_cur) ? begin_wr : begin_cur;

    // arming needs the unit on; a software arm beats a same-cycle done
    assign arm_rise  = ctrl_wr & arm_wr & on_wr & ~arm_cur;
    assign arm_after = on_after & (arm_rise
                     | (ctrl_wr ? (arm_wr & arm_cur) : (arm_cur & ~trace_done)));

    // a reset event beats a same-cycle software write, which is lost;
    // the event branches never look at the write decode
    always_comb begin
        ctrl_next = ctrl_reg;
        case (rst_kind)
            dts_pkg::DTS_RST_FULL: begin
                ctrl_next = dts_pkg::CTRL_RST;
            end
            dts_pkg::DTS_RST_END_RUN: begin
                ctrl_next[dts_pkg::CTRL_ARM_BIT] = 1'b0;
            end
            dts_pkg::DTS_RST_END_TRACE: begin
                ctrl_next[dts_pkg::CTRL_ARM_BIT] = 1'b0;
            end
            dts_pkg::DTS_RST_NONE: begin
                ctrl_next[dts_pkg::CTRL_ON_BIT]    = on_after;
                ctrl_next[dts_pkg::CTRL_ARM_BIT]   = arm_after;
                ctrl_next[dts_pkg::CTRL_BEGIN_BIT] = begin_after;
            end
            default: begin
                ctrl_next = dts_pkg::CTRL_RST;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= dts_pkg::CTRL_RST;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // comparator hit flags

    // matches count from the arming edge onward, and only while on
    assign armed_now = on_cur & (arm_cur | arm_rise);
    assign hit_a     = cmp_a_match & armed_now;
    assign hit_b     = cmp_b_match & armed_now;
    assign hit_c     = cmp_c_match & armed_now;

    // flags clear only on arming or a full-type reset, so the host
    // may read them at leisure after the run ends
    always_comb begin
        cmp_a_hit_flag_next = cmp_a_hit_flag_reg;
        cmp_b_hit_flag_next = cmp_b_hit_flag_reg;
        cmp_c_hit_flag_next = cmp_c_hit_flag_reg;
        case (rst_kind)
            dts_pkg::DTS_RST_FULL: begin
                cmp_a_hit_flag_next = 1'b0;
                cmp_b_hit_flag_next = 1'b0;
                cmp_c_hit_flag_next = 1'b0;
            end
            dts_pkg::DTS_RST_END_RUN: begin
                // value is free here; holding is the cheapest choice
                cmp_a_hit_flag_next = cmp_a_hit_flag_reg;
                cmp_b_hit_flag_next = cmp_b_hit_flag_reg;
                cmp_c_hit_flag_next = cmp_c_hit_flag_reg;
            end
            dts_pkg::DTS_RST_END_TRACE: begin
                cmp_a_hit_flag_next = cmp_a_hit_flag_reg;
                cmp_b_hit_flag_next = cmp_b_hit_flag_reg;
                cmp_c_hit_flag_next = cmp_c_hit_flag_reg;
            end
            dts_pkg::DTS_RST_NONE: begin
                cmp_a_hit_flag_next = sticky_next(cmp_a_hit_flag_reg,
                                                  arm_rise, hit_a);
                cmp_b_hit_flag_next = sticky_next(cmp_b_hit_flag_reg,
                                                  arm_rise, hit_b);
                cmp_c_hit_flag_next = sticky_next(cmp_c_hit_flag_reg,
                                                  arm_rise, hit_c);
            end
            default: begin
                cmp_a_hit_flag_next = 1'b0;
                cmp_b_hit_flag_next = 1'b0;
                cmp_c_hit_flag_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_a_hit_flag_reg <= 1'b0;
            cmp_b_hit_flag_reg <= 1'b0;
            cmp_c_hit_flag_reg <= 1'b0;
        end else begin
            cmp_a_hit_flag_reg <= cmp_a_hit_flag_next;
            cmp_b_hit_flag_reg <= cmp_b_hit_flag_next;
            cmp_c_hit_flag_reg <= cmp_c_hit_flag_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // capture count

    // the host reads the count once and fetches that many words,
    // so readout must never move it backwards
    // end-run and kept end-trace resets leave the count alone
    assign fill_clear = (rst_kind == dts_pkg::DTS_RST_FULL)
                      | ((rst_kind == dts_pkg::DTS_RST_NONE) & arm_rise);
    assign fill_step  = fifo_word_stored & on_cur
                      & (rst_kind != dts_pkg::DTS_RST_FULL);

    dts_fill_counter u_fill (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (fill_clear),
        .step    (fill_step),
        .count   (capture_fill_count)
    );

    ////////////////////////////////////////////////////////////////////////
    // readable registers

    // pending reads zero whenever the unit is off
    assign trace_pending_flag = on_cur & arm_cur;

    assign debug_status_reg = {cmp_a_hit_flag_reg,
                               cmp_b_hit_flag_reg,
                               cmp_c_hit_flag_reg,
                               4'h0,
                               trace_pending_flag};
    assign capture_fill_reg = {4'h0, capture_fill_count};

    // unmapped offsets read zero and raise pslverr in the access phase
    assign read_mux = hit_ctrl ? ctrl_reg
                    : hit_stat ? debug_status_reg
                    : hit_fill ? capture_fill_reg
                               : dts_pkg::REG_ZERO;

    // read data is captured in the setup cycle and held through access
    // so prdata never moves while the master samples it
    assign rdata_next  = setup_phase
                       ? {{(dts_pkg::DATA_W - dts_pkg::REG_W){1'b0}}, read_mux}
                       : rdata_reg;
    assign slverr_next = setup_phase ? ~addr_mapped : slverr_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg  <= dts_pkg::DATA_ZERO;
            slverr_reg <= 1'b0;
        end else begin
            rdata_reg  <= rdata_next;
            slverr_reg <= slverr_next;
        end
    end

    assign prdata  = rdata_reg;
    assign pslverr = slverr_reg & access_phase;

    ////////////////////////////////////////////////////////////////////////
    // outputs to trigger and fifo logic

    // arm state leaves through its own flop, loaded from the next
    // control value so it never lags the pending bit
    assign armed_out_next = ctrl_next[dts_pkg::CTRL_ON_BIT]
                          & ctrl_next[dts_pkg::CTRL_ARM_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_out_reg <= 1'b0;
        end else begin
            armed_out_reg <= armed_out_next;
        end
    end

    assign debug_unit_on  = on_cur;
    assign trace_armed    = armed_out_reg;
    assign trig_at_start  = begin_cur;
    // the fifo may only store while the unit is on and armed
    assign capture_enable = armed_out_reg;

endmodule : dts_top

// ===== core/dts_pkg.sv
/*
 * constants and types shared by the debug trace status block: register
 * offsets, field positions, reset values and the reset-event kinds.
 * assumes an apb slave with 32-bit data and one aligned word per register.
 */
// What this block does
// - set comparator a hit flag, status bit 7, on an a match after arming
// - set comparator b hit flag, status bit 6, on a b match after arming
// - set comparator c hit flag, status bit 5, on a c match after arming
// - status bits 4..1 and count bits 7..4 read as zero
// - trace pending flag, status bit 0, reads 1 while armed, else 0
// - while unit is on, pending flag copies the arm control bit
// - end-run reset clears pending flag; hit flags may hold any value
// - end-trace reset with unit on and trigger-at-start 0 keeps hit flags
// - capture count resets to 0 on power-on or non-end-run reset
// - end-trace reset with unit on and trigger-at-start 0 keeps the count
// - capture count is the binary number of valid fifo words
// - capture count clears to zero when the unit becomes armed
// - capture count steps by one per word written into the fifo
// - capture count saturates at eight despite further stores
// - capture count never decrements on fifo readout
// - arming, triggering and fifo storage happen only while unit is on

package dts_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W  = 8;
    localparam int unsigned FILL_W = 4;

    localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_STAT = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_FILL = 12'h008;

    localparam int unsigned CTRL_ON_BIT    = 0;
    localparam int unsigned CTRL_ARM_BIT   = 1;
    localparam int unsigned CTRL_BEGIN_BIT = 2;

    localparam int unsigned STAT_A_BIT    = 7;
    localparam int unsigned STAT_B_BIT    = 6;
    localparam int unsigned STAT_C_BIT    = 5;
    localparam int unsigned STAT_PEND_BIT = 0;

    localparam logic [REG_W-1:0]  CTRL_RST   = 8'h00;
    localparam logic [REG_W-1:0]  REG_ZERO   = 8'h00;
    localparam logic [DATA_W-1:0] DATA_ZERO  = 32'h0000_0000;
    localparam logic [FILL_W-1:0] FILL_ZERO  = 4'h0;
    localparam logic [FILL_W-1:0] FILL_ONE   = 4'h1;
    localparam logic [FILL_W-1:0] FILL_MAX   = 4'h8;

    typedef enum logic [1:0] {
        DTS_RST_NONE,
        DTS_RST_FULL,
        DTS_RST_END_RUN,
        DTS_RST_END_TRACE
    } dts_rst_kind_t;

endpackage : dts_pkg

// ===== core/dts_fill_counter.sv
/*
 * saturating count of words captured into the eight-word trace fifo.
 * assumes clear and step are single-cycle strobes synchronous to pclk.
 */
`timescale 1ns/100ps

module dts_fill_counter (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       clear,
    input  wire logic                       step,
    output logic [dts_pkg::FILL_W-1:0]      count
);

    logic [dts_pkg::FILL_W-1:0] count_reg;
    logic [dts_pkg::FILL_W-1:0] count_next;
    logic [dts_pkg::FILL_W-1:0] count_inc;
    logic                       at_max;

    ////////////////////////////////////////////////////////////////////////

    assign at_max    = (count_reg == dts_pkg::FILL_MAX);
    // stops at eight, never wraps, no decrement path exists
    assign count_inc = at_max ? count_reg
                              : count_reg + dts_pkg::FILL_ONE;

    // a word stored in the arming cycle is counted, not lost
    assign count_next = clear ? (step ? dts_pkg::FILL_ONE : dts_pkg::FILL_ZERO)
                      : step  ? count_inc
                              : count_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= dts_pkg::FILL_ZERO;
        end else begin
            count_reg <= count_next;
        end
    end

    assign count = count_reg;

endmodule : dts_fill_counter

// ===== bench/dts_top_assertions.sv
/*
 * concurrent checks on the ports of dts_top, attached by bind.
 * assumes the apb slave answers with zero wait states, one register per word.
 */
`timescale 1ns/100ps

module dts_top_checker (
    input logic                       pclk,
    input logic                       presetn,
    input logic                       psel,
    input logic                       penable,
    input logic                       pwrite,
    input logic [dts_pkg::ADDR_W-1:0] paddr,
    input logic [dts_pkg::DATA_W-1:0] pwdata,
    input logic [dts_pkg::DATA_W-1:0] prdata,
    input logic                       pready,
    input logic                       pslverr,
    input logic                       cmp_a_match,
    input logic                       cmp_b_match,
    input logic                       cmp_c_match,
    input logic                       fifo_word_stored,
    input logic                       trace_done,
    input logic                       non_end_run_rst,
    input logic                       end_run_rst,
    input logic                       end_trace_rst,
    input logic                       debug_unit_on,
    input logic                       trace_armed,
    input logic                       trig_at_start,
    input logic                       capture_enable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire rd_acc = psel && penable && !pwrite;
    wire rd_st  = rd_acc && (paddr == dts_pkg::OFS_STAT);
    wire rd_fl  = rd_acc && (paddr == dts_pkg::OFS_FILL);

    // status is sampled at the setup edge, hence one cycle back
    a_pend_mirror: assert property (rd_st |-> prdata[0] == $past(trace_armed))
        else $error("pending bit differs from arm state");
    a_stat_rsvd: assert property (rd_st |-> prdata[4:1] == 4'h0 && prdata[31:8] == 24'h000000)
        else $error("reserved status bits not zero");
    a_fill_range: assert property (rd_fl |-> prdata[31:4] == 28'h0000000 && prdata[3:0] <= 4'h8)
        else $error("capture count out of range");
    a_arm_needs_on: assert property (trace_armed |-> debug_unit_on)
        else $error("armed while unit off");
    a_cap_follow: assert property (capture_enable == trace_armed)
        else $error("capture enable without arming");
    a_endrun_clear: assert property (end_run_rst |=> !trace_armed)
        else $error("end-run reset left unit armed");
    a_endtrace_keep: assert property (end_trace_rst && debug_unit_on && !trig_at_start && !non_end_run_rst
        |=> !trace_armed && debug_unit_on)
        else $error("end-trace reset handled as full reset");
    a_nonend_clear: assert property (non_end_run_rst |=> !debug_unit_on ##1 !trace_armed[*2])
        else $error("non-end-run reset kept control state");

    c_arm_match: cover property (trace_armed && cmp_a_match);
    c_end_trace: cover property (end_trace_rst && debug_unit_on);
    c_bad_addr: cover property (pslverr);
    c_begin_trace: cover property (end_trace_rst && trig_at_start);
endmodule : dts_top_checker

bind dts_top dts_top_checker i_dts_top_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_a_match(cmp_a_match), .cmp_b_match(cmp_b_match), .cmp_c_match(cmp_c_match),
    .fifo_word_stored(fifo_word_stored), .trace_done(trace_done),
    .non_end_run_rst(non_end_run_rst), .end_run_rst(end_run_rst), .end_trace_rst(end_trace_rst),
    .debug_unit_on(debug_unit_on), .trace_armed(trace_armed), .trig_at_start(trig_at_start),
    .capture_enable(capture_enable));

// ===== bench/dts_host_model.sv
/*
 * host development system: an apb master that reads trace results.
 * assumes one rising-edge clock; released address and data are inverted.
 */
`timescale 1ns/100ps

module dts_host_model (
    input  wire logic                       pclk,
    input  wire logic [dts_pkg::DATA_W-1:0] prdata,
    input  wire logic                       pready,
    output logic                            psel,
    output logic                            penable,
    output logic                            pwrite,
    output logic [dts_pkg::ADDR_W-1:0]      paddr,
    output logic [dts_pkg::DATA_W-1:0]      pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
    end

    // one apb transfer: a setup cycle, then access until pready, read data returned in q
    task xfer(input logic w, input logic [dts_pkg::ADDR_W-1:0] a, input logic [dts_pkg::DATA_W-1:0] d,
              output logic [dts_pkg::DATA_W-1:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : dts_host_model

// ===== bench/testbench.sv
/*
 * self-checking bench for dts_top: the host model drives apb, the bench
 * drives event strobes and notes expected reads in a queue.
 * assumes zero-wait apb and single-cycle event strobes.
 */
`timescale 1ns/100ps

module testbench;
    logic                       pclk;
    logic                       presetn;
    logic                       psel;
    logic                       penable;
    logic                       pwrite;
    logic [dts_pkg::ADDR_W-1:0] paddr;
    logic [dts_pkg::DATA_W-1:0] pwdata;
    logic [dts_pkg::DATA_W-1:0] prdata;
    logic                       pready;
    logic                       pslverr;
    logic [7:0]                 ev;
    logic [32:0]                exp_q[$];
    logic [32:0]                e;
    int                         err_total;
    int                         compares;
    int                         n;

    dts_host_model i_dts_host_model (.pclk(pclk), .prdata(prdata), .pready(pready), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    dts_top i_dts_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmp_a_match(ev[7]), .cmp_b_match(ev[6]), .cmp_c_match(ev[5]), .fifo_word_stored(ev[4]),
        .trace_done(ev[3]), .non_end_run_rst(ev[2]), .end_run_rst(ev[1]), .end_trace_rst(ev[0]),
        .debug_unit_on(), .trace_armed(), .trig_at_start(), .capture_enable());

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task test_done;
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done

    task chk(input string what, input logic [32:0] x, input logic [32:0] y);
        compares++;
        if (x !== y) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, x, y);
        end
    endtask : chk

    task wr(input logic [dts_pkg::ADDR_W-1:0] a, input logic [7:0] d);
        logic [dts_pkg::DATA_W-1:0] q;
        i_dts_host_model.xfer(1'b1, a, {24'h000000, d}, q);
    endtask : wr

    task rd(input logic [dts_pkg::ADDR_W-1:0] a, input logic [7:0] d, input logic er);
        logic [dts_pkg::DATA_W-1:0] q;
        exp_q.push_back({er, 24'h000000, d});
        i_dts_host_model.xfer(1'b0, a, 32'h00000000, q);
    endtask : rd

    // strobe held for c back-to-back cycles
    task pulse(input logic [7:0] v, input int c);
        repeat (c) @(posedge pclk) ev <= v;
        @(posedge pclk) ev <= 8'h00;
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
            if (exp_q.size() == 0) begin
                e = 33'h0;
                chk("unexpected read", 33'h1, 33'h0);
            end else begin
                e = exp_q.pop_front();
                chk("prdata", {1'b0, e[31:0]}, {1'b0, prdata});
                chk("pslverr", {32'h0, e[32]}, {32'h0, pslverr});
            end
        end
    end

    initial begin
        #100000;
        err_total++;
        test_done();
    end

    initial begin
        presetn = 1'b0;
        ev = 8'h00;
        err_total = 0;
        compares = 0;
        void'($urandom(32'h292d060b));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(dts_pkg::OFS_STAT, 8'h00, 1'b0);
        rd(dts_pkg::OFS_FILL, 8'h00, 1'b0);
        rd(12'h00c, 8'h00, 1'b1);
        wr(dts_pkg::OFS_CTRL, 8'h02);
        rd(dts_pkg::OFS_STAT, 8'h00, 1'b0);
        for (int k = 0; k < 3; k++) begin
            wr(dts_pkg::OFS_CTRL, 8'h01);
            wr(dts_pkg::OFS_CTRL, 8'h03);
            rd(dts_pkg::OFS_FILL, 8'h00, 1'b0);
            pulse(8'h80 >> k, 1);
            n = $urandom_range(12, 1);
            pulse(8'h10, n);
            rd(dts_pkg::OFS_STAT, (8'h80 >> k) | 8'h01, 1'b0);
            rd(dts_pkg::OFS_FILL, (n > 8) ? 8'h08 : 8'(n), 1'b0);
        end
        pulse(8'h08, 1);
        pulse(8'h80, 1);
        rd(dts_pkg::OFS_STAT, 8'h20, 1'b0);
        wr(dts_pkg::OFS_CTRL, 8'h03);
        pulse(8'h80, 1);
        pulse(8'h10, 3);
        pulse(8'h01, 1);
        rd(dts_pkg::OFS_STAT, 8'h80, 1'b0);
        rd(dts_pkg::OFS_FILL, 8'h03, 1'b0);
        wr(dts_pkg::OFS_CTRL, 8'h03);
        pulse(8'h02, 1);
        rd(dts_pkg::OFS_STAT, 8'h00, 1'b0);
        pulse(8'h10, 2);
        pulse(8'h04, 1);
        rd(dts_pkg::OFS_FILL, 8'h00, 1'b0);
        pulse(8'h90, 2);
        rd(dts_pkg::OFS_FILL, 8'h00, 1'b0);
        wr(dts_pkg::OFS_STAT, 8'hff);
        rd(dts_pkg::OFS_STAT, 8'h00, 1'b0);
        wr(dts_pkg::OFS_CTRL, 8'h05);
        wr(dts_pkg::OFS_CTRL, 8'h07);
        wr(dts_pkg::OFS_CTRL, 8'h03);
        rd(dts_pkg::OFS_CTRL, 8'h07, 1'b0);
        pulse(8'h90, 1);
        pulse(8'h01, 1);
        rd(dts_pkg::OFS_STAT, 8'h00, 1'b0);
        rd(dts_pkg::OFS_FILL, 8'h00, 1'b0);
        wr(dts_pkg::OFS_CTRL, 8'h03);
        pulse(8'h10, 1);
        @(posedge pclk) presetn <= 1'b0;
        @(posedge pclk) presetn <= 1'b1;
        rd(dts_pkg::OFS_FILL, 8'h00, 1'b0);
        repeat (2) @(posedge pclk);
        test_done();
    end
endmodule : testbench
